// File: hdl/resistance_threshold_config.v
// Summary of operation
// - Shutdown is ignored unless the shutdown-permit bit, reset 0, is 1.
// - With optimized drive set, resistance conversions never complete.
// - With optimized drive clear (reset), both conversion kinds run in active mode only.
// - The upper limit is the high byte times 256 plus the low byte.
// - The above flag is set when a result is strictly above the upper limit.
// - An upper low-byte write is buffered until the upper high-byte write.
// - The lower limit is the high byte shifted up eight bits plus low byte.
// - The below flag is set when a result is strictly below the lower limit.
// - A lower low-byte write is buffered until the lower high-byte write.
// - Limit writes are applied while converting, without sleep mode.
`timescale 1ns/1ps
`include "resistance_threshold_config_regs.vh"

module resistance_threshold_config #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Register port from the serial host interface
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // Conversion core
    input wire rp_done,
    input wire [WIDTH-1:0] resistance_result,
    output wire resistance_conv_enable,
    output wire inductance_conv_enable,
    output wire resistance_result_valid,
    // Mode and status
    output wire shutdown_active,
    output wire [1:0] operating_mode_field,
    output wire shutdown_permit,
    output wire inductance_optimized_drive,
    output wire above_upper_limit_flag,
    output wire below_lower_limit_flag
);

    // Stored registers and their combinational next values
    reg [7:0] alternate_configuration_reg;
    reg [7:0] alternate_configuration_next;
    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg [7:0] upper_low_buf_reg;
    reg [7:0] upper_low_reg;
    reg [7:0] upper_high_reg;
    reg [7:0] lower_low_buf_reg;
    reg [7:0] lower_low_reg;
    reg [7:0] lower_high_reg;
    reg [7:0] rdata_next;

    // Decoded strobes and derived values
    wire wr_alt;
    wire wr_mode;
    wire wr_upper_low;
    wire wr_upper_high;
    wire wr_lower_low;
    wire wr_lower_high;
    wire shutdown_request;
    wire [WIDTH-1:0] upper_limit;
    wire [WIDTH-1:0] lower_limit;
    wire conv_running;

    function [WIDTH-1:0] join_bytes;
        input [7:0] high_byte;
        input [7:0] low_byte;
        begin
            join_bytes = {high_byte, low_byte};
        end
    endfunction

    // One address match per register keeps the decode in a single place
    function write_hit;
        input strobe;
        input [7:0] addr;
        input [7:0] target;
        begin
            write_hit = strobe && (addr == target);
        end
    endfunction

    assign wr_alt = write_hit(reg_wr, reg_addr, `ALTERNATE_ADDR);
    assign wr_mode = write_hit(reg_wr, reg_addr, `START_CONFIG_ADDR);
    assign wr_upper_low = write_hit(reg_wr, reg_addr, `UPPER_LOW_ADDR);
    assign wr_upper_high = write_hit(reg_wr, reg_addr, `UPPER_HIGH_ADDR);
    assign wr_lower_low = write_hit(reg_wr, reg_addr, `LOWER_LOW_ADDR);
    assign wr_lower_high = write_hit(reg_wr, reg_addr, `LOWER_HIGH_ADDR);

    // Reserved bits are not stored, so a careless host cannot set them
    always @* begin
        alternate_configuration_next = alternate_configuration_reg;
        if (wr_alt) begin
            alternate_configuration_next = reg_wdata & `ALT_WRITABLE_MASK;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            alternate_configuration_reg <= `ALTERNATE_RESET;
        end else begin
            alternate_configuration_reg <= alternate_configuration_next;
        end
    end

    assign shutdown_permit =
        alternate_configuration_reg[`ALT_SHUTDOWN_PERMIT_BIT];
    assign inductance_optimized_drive =
        alternate_configuration_reg[`ALT_OPTIMIZED_BIT];

    // A refused shutdown leaves the previous mode in place
    // Reserved code 3 is kept as written; it runs no conversions
    assign shutdown_request = (reg_wdata[1:0] == `MODE_SHUTDOWN);

    always @* begin
        mode_next = mode_reg;
        if (wr_mode) begin
            if (!shutdown_request || shutdown_permit) begin
                mode_next = reg_wdata[1:0];
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    assign operating_mode_field = mode_reg;
    assign shutdown_active = (mode_reg == `MODE_SHUTDOWN);
    assign conv_running = (mode_reg == `MODE_ACTIVE);

    // Low bytes are shadowed until the high byte commits, so a compare
    // in mid-update never sees half of a new limit
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            upper_low_buf_reg <= `LIMIT_BYTE_RESET;
            upper_low_reg <= `LIMIT_BYTE_RESET;
            upper_high_reg <= `LIMIT_BYTE_RESET;
        end else begin
            if (wr_upper_low) begin
                upper_low_buf_reg <= reg_wdata;
            end
            if (wr_upper_high) begin
                upper_high_reg <= reg_wdata;
                upper_low_reg <= upper_low_buf_reg;
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lower_low_buf_reg <= `LIMIT_BYTE_RESET;
            lower_low_reg <= `LIMIT_BYTE_RESET;
            lower_high_reg <= `LIMIT_BYTE_RESET;
        end else begin
            if (wr_lower_low) begin
                lower_low_buf_reg <= reg_wdata;
            end
            if (wr_lower_high) begin
                lower_high_reg <= reg_wdata;
                lower_low_reg <= lower_low_buf_reg;
            end
        end
    end

    assign upper_limit = join_bytes(upper_high_reg, upper_low_reg);
    assign lower_limit = join_bytes(lower_high_reg, lower_low_reg);

    // Read data registered; unmapped addresses read zero
    // A low-byte address returns the buffer, so a pending byte can be
    // checked before the high byte commits it
    always @* begin
        rdata_next = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `ALTERNATE_ADDR: rdata_next = alternate_configuration_reg;
                `UPPER_LOW_ADDR: rdata_next = upper_low_buf_reg;
                `UPPER_HIGH_ADDR: rdata_next = upper_high_reg;
                `LOWER_LOW_ADDR: rdata_next = lower_low_buf_reg;
                `LOWER_HIGH_ADDR: rdata_next = lower_high_reg;
                `START_CONFIG_ADDR: rdata_next = {6'h00, mode_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // Optimized drive suppresses resistance conversions entirely
    // A late done pulse after the bit is set is dropped, not compared
    assign resistance_conv_enable =
        conv_running && !inductance_optimized_drive;
    assign inductance_conv_enable = conv_running;
    assign resistance_result_valid = rp_done && resistance_conv_enable;

    threshold_compare #(
        .WIDTH(WIDTH)
    ) u_compare (
        .mclk(mclk),
        .rst_n(rst_n),
        .result_valid(resistance_result_valid),
        .resistance_result(resistance_result),
        .resistance_upper_limit(upper_limit),
        .resistance_lower_limit(lower_limit),
        .above_upper_limit_flag(above_upper_limit_flag),
        .below_lower_limit_flag(below_lower_limit_flag)
    );

endmodule

// File: hdl/resistance_threshold_config_regs.vh
`ifndef RESISTANCE_THRESHOLD_CONFIG_REGS_VH
`define RESISTANCE_THRESHOLD_CONFIG_REGS_VH

// Register addresses on the internal register port
`define ALTERNATE_ADDR 8'h05
`define UPPER_LOW_ADDR 8'h06
`define UPPER_HIGH_ADDR 8'h07
`define LOWER_LOW_ADDR 8'h08
`define LOWER_HIGH_ADDR 8'h09
`define START_CONFIG_ADDR 8'h0B

// Field positions
`define ALT_OPTIMIZED_BIT 0
`define ALT_SHUTDOWN_PERMIT_BIT 1
`define ALT_WRITABLE_MASK 8'h03

// Operating mode encodings
`define MODE_ACTIVE 2'h0
`define MODE_SLEEP 2'h1
`define MODE_SHUTDOWN 2'h2

// Reset values
`define ALTERNATE_RESET 8'h00
`define LIMIT_BYTE_RESET 8'h00
`define MODE_RESET 2'h1

`endif

// File: hdl/threshold_compare.v
`timescale 1ns/1ps
`include "resistance_threshold_config_regs.vh"

module threshold_compare #(
    parameter WIDTH = 16
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Conversion result
    input wire result_valid,
    input wire [WIDTH-1:0] resistance_result,
    // Committed limits
    input wire [WIDTH-1:0] resistance_upper_limit,
    input wire [WIDTH-1:0] resistance_lower_limit,
    // Flags
    output reg above_upper_limit_flag,
    output reg below_lower_limit_flag
);

    // Flags hold between conversions; limits sampled at the result edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            above_upper_limit_flag <= 1'b0;
            below_lower_limit_flag <= 1'b0;
        end else if (result_valid) begin
            above_upper_limit_flag <=
                (resistance_result > resistance_upper_limit);
            below_lower_limit_flag <=
                (resistance_result < resistance_lower_limit);
        end
    end

endmodule

// File: tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire mclk,
    // Register port
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    input wire [7:0] reg_rdata
);
    // One strobe per access; read data is taken a cycle after the pulse
    task acc(input logic w, input logic [7:0] a, input logic [7:0] v,
        output logic [7:0] q);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = w;
        reg_rd = !w;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~v; // Stale data must not look valid
        @(negedge mclk);
        q = reg_rdata;
    endtask
endmodule

// File: tb/resistance_threshold_config_asserts.sv
`timescale 1ns/1ps
module rtc_chk (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Register port
    input wire reg_wr,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    // Conversion and status
    input wire rp_done,
    input wire resistance_conv_enable,
    input wire resistance_result_valid,
    input wire shutdown_active,
    input wire [1:0] operating_mode_field,
    input wire shutdown_permit,
    input wire inductance_optimized_drive,
    input wire above_upper_limit_flag,
    input wire below_lower_limit_flag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire mode_wr = reg_wr && reg_addr == 8'h0B;
    wire alt_wr = reg_wr && reg_addr == 8'h05;
    conv_gate_a: assert property (resistance_conv_enable ==
        (operating_mode_field == 2'h0 && !inductance_optimized_drive))
        else $error("conversion enable wrong");
    valid_gate_a: assert property (resistance_result_valid ==
        (rp_done && resistance_conv_enable)) else $error("valid wrong");
    flag_hold_a: assert property (!resistance_result_valid |=>
        $stable({above_upper_limit_flag, below_lower_limit_flag}))
        else $error("flag moved without conversion");
    shut_gate_a: assert property (mode_wr && reg_wdata[1:0] == 2'h2 &&
        !shutdown_permit |=> $stable(operating_mode_field))
        else $error("shutdown taken without permit");
    mode_set_a: assert property (mode_wr && reg_wdata[1:0] < 2'h2 |=>
        operating_mode_field == $past(reg_wdata[1:0]))
        else $error("mode not written");
    shut_stat_a: assert property (shutdown_active ==
        (operating_mode_field == 2'h2)) else $error("shutdown status wrong");
    permit_wr_a: assert property (alt_wr |=>
        shutdown_permit == $past(reg_wdata[1])) else $error("permit wrong");
    opt_wr_a: assert property (alt_wr |=>
        inductance_optimized_drive == $past(reg_wdata[0]))
        else $error("optimized drive bit wrong");
    cover property (resistance_result_valid ##1 above_upper_limit_flag);
    cover property (resistance_result_valid ##1 below_lower_limit_flag);
    cover property (rp_done && !resistance_conv_enable);
    cover property (shutdown_active);
endmodule
bind resistance_threshold_config rtc_chk i_chk (.mclk, .rst_n, .reg_wr,
    .reg_addr, .reg_wdata, .rp_done, .resistance_conv_enable,
    .resistance_result_valid, .shutdown_active, .operating_mode_field,
    .shutdown_permit, .inductance_optimized_drive, .above_upper_limit_flag,
    .below_lower_limit_flag);

// File: tb/resistance_threshold_config_test.sv
`timescale 1ns/1ps
module resistance_threshold_config_test;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic rp_done = 1'b0;
    logic [15:0] res = 16'h0000;
    logic [7:0] d;
    wire wr, rd, rv, ce, ie, sd, sp, od, ab, bl;
    wire [7:0] ad, wd, rdat;
    wire [1:0] md;
    int num_errors = 0;
    int n_checks = 0;
    host_model i_host (.mclk(mclk), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat));
    resistance_threshold_config i_dut (.mclk(mclk), .rst_n(rst_n),
        .reg_wr(wr), .reg_rd(rd), .reg_addr(ad), .reg_wdata(wd),
        .reg_rdata(rdat), .rp_done(rp_done), .resistance_result(res),
        .resistance_conv_enable(ce), .inductance_conv_enable(ie),
        .resistance_result_valid(rv), .shutdown_active(sd),
        .operating_mode_field(md), .shutdown_permit(sp),
        .inductance_optimized_drive(od), .above_upper_limit_flag(ab),
        .below_lower_limit_flag(bl));
    initial forever #12.5 mclk = ~mclk;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conv(input logic [15:0] r);
        @(negedge mclk);
        rp_done = 1'b1;
        res = r;
        @(negedge mclk);
        rp_done = 1'b0;
        res = ~r;
    endtask
    task t_reset;
        for (int a = 5; a < 10; a++) begin
            i_host.acc(1'b0, 8'(a), 8'h00, d);
            chk(d, 8'h00);
        end
        i_host.acc(1'b0, 8'h0F, 8'h00, d);
        chk(d, 8'h00);
        chk({ie, md}, 3'b001);
    endtask
    task t_limits;
        i_host.acc(1'b1, 8'h0B, 8'h00, d);
        i_host.acc(1'b1, 8'h06, 8'h34, d);
        conv(16'h0001);
        chk(ab, 1'b1);
        i_host.acc(1'b1, 8'h07, 8'h12, d);
        conv(16'h1234);
        chk(ab, 1'b0);
        conv(16'h1235);
        chk(ab, 1'b1);
        i_host.acc(1'b1, 8'h08, 8'hFF, d);
        conv(16'h0000);
        chk(bl, 1'b0);
        i_host.acc(1'b1, 8'h09, 8'h01, d);
        conv(16'h01FE);
        chk({ab, bl}, 2'b01);
        conv(16'h01FF);
        chk(bl, 1'b0);
        i_host.acc(1'b0, 8'h06, 8'h00, d);
        chk(d, 8'h34);
        i_host.acc(1'b0, 8'h07, 8'h00, d);
        chk(d, 8'h12);
        i_host.acc(1'b0, 8'h08, 8'h00, d);
        chk(d, 8'hFF);
        i_host.acc(1'b0, 8'h09, 8'h00, d);
        chk(d, 8'h01);
    endtask
    task t_modes;
        // Reserved bits set on purpose: the device must drop them
        // Drive-ok override sits outside this slice; the host sets it too
        i_host.acc(1'b1, 8'h05, 8'hFD, d);
        i_host.acc(1'b0, 8'h05, 8'h00, d);
        chk(d, 8'h01);
        chk({ce, ie}, 2'b01);
        conv(16'hFFFF);
        chk(ab, 1'b0);
        i_host.acc(1'b1, 8'h05, 8'h00, d);
        chk({ce, ie}, 2'b11);
        conv(16'hFFFF);
        chk(ab, 1'b1);
        i_host.acc(1'b1, 8'h0B, 8'h01, d);
        chk({ce, ie, md}, 4'b0001);
        conv(16'h0000);
        chk({ab, bl}, 2'b10);
        i_host.acc(1'b1, 8'h0B, 8'h02, d);
        chk(md, 2'h1);
        i_host.acc(1'b1, 8'h05, 8'h02, d);
        i_host.acc(1'b1, 8'h0B, 8'h02, d);
        chk({sd, sp}, 2'b11);
        i_host.acc(1'b0, 8'h0B, 8'h00, d);
        chk(d, 8'h02);
    endtask
    task results;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        t_reset;
        t_limits;
        t_modes;
        results;
    end
    // About 95 cycles are needed; the limit leaves a wide margin
    initial begin
        #100000;
        num_errors++;
        results;
    end
endmodule
